// ===== verilog/obt_pkg.sv
package obt_pkg;
   // register offsets (byte addresses on the 8-bit local port)
   localparam logic [7:0] OBT_ADDR_COUNT_LOW = 8'h20;
   localparam logic [7:0] OBT_ADDR_CTRL_STATUS = 8'h21;
   localparam logic [7:0] OBT_ADDR_IRQ_MASK = 8'h22;
   localparam logic [7:0] OBT_ADDR_CLK_SELECT = 8'h23;
   // control/status field positions
   localparam int OBT_BIT_C9 = 7;
   localparam int OBT_BIT_C8 = 6;
   localparam int OBT_BIT_MODE_HI = 5;
   localparam int OBT_BIT_MODE_LO = 4;
   localparam int OBT_BIT_IRQ_EN = 3;
   localparam int OBT_BIT_DONE_EDGE = 2;
   localparam int OBT_BIT_DATA = 1;
   localparam int OBT_BIT_EMPTY_OVF = 0;
   // reset values
   localparam logic [7:0] OBT_RST_COUNT_LOW = 8'h00;
   localparam logic [7:0] OBT_RST_CTRL = 8'h00;
   localparam logic [1:0] OBT_RST_IRQ_MASK = 2'h3;
   localparam logic [1:0] OBT_RST_CLK_SELECT = 2'h0;
   // interrupt vector addresses
   localparam logic [7:0] OBT_VEC_EMPTY_OVF = 8'h04;
   localparam logic [7:0] OBT_VEC_DONE_EDGE = 8'h02;
   // timing
   localparam int OBT_CLK_HZ = 20000000;
   localparam int OBT_COUNT_W = 10;
   localparam logic [9:0] OBT_COUNT_MAX = 10'h3ff;

   typedef enum logic [1:0] {
      OBT_MODE_OFF = 2'b00,
      OBT_MODE_TX_UNKEYED = 2'b01,
      OBT_MODE_RX = 2'b10,
      OBT_MODE_TX_KEYED = 2'b11
   } obt_mode_t;

   typedef enum logic [1:0] {
      OBT_ST_IDLE = 2'b00,
      OBT_ST_TIMING = 2'b01,
      OBT_ST_RX = 2'b10
   } obt_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } obt_bus_req_t;

   typedef struct packed {
      logic done_edge;
      logic empty_ovf;
   } obt_flags_t;
endpackage

// ===== verilog/obt_tick_gen.sv
`timescale 1ns/1ns
// processor clock enable: crystal divided by 16/32/64/128
module obt_tick_gen
   import obt_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] div_sel_i,
   output logic tick_o
);
   logic [6:0] div_cnt;
   logic [6:0] terminal;
   logic hit;

   // select 11 -> /16, 10 -> /32, 01 -> /64, 00 -> /128
   assign terminal = 7'(({3'h0, 4'hf} << (2'd3 - div_sel_i)) | 7'h0f);
   assign hit = ((div_cnt & terminal) == terminal);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         div_cnt <= 7'h00;
         tick_o <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 7'h01;
         tick_o <= hit;
      end
   end
endmodule // obt_tick_gen

// ===== verilog/obt_edge_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser plus edge detector on the settled stage
module obt_edge_sync (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta;
   logic sync;
   logic prev;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin_i;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level_o = sync;
   assign rise_o = sync & ~prev;
   assign fall_o = ~sync & prev;
endmodule // obt_edge_sync

// ===== verilog/obt_bit_timer.sv
`timescale 1ns/1ns
// How it works
// - each mark or space lasts one processor clock times count plus one.
// - ten-bit count is low byte plus control bits seven and six.
// - mode 00 off, 01 transmit unkeyed, 10 receive, 11 transmit keyed.
// - with interrupt enable bit three and its mask register bit set, each flag raises its own request.
// - empty/overflow vectors to address four, done/edge to address two.
// - transmit sets done flag when buffer empty and counter reached zero.
// - receive sets edge flag on each edge at the sense pin.
// - reading the control register clears both status flags.
// - taking the buffered bit sets the empty flag and requests interrupt.
// - receive stores edge polarity in data bit, one rising, zero falling.
// - receive count holds processor cycles since previous edge.
// - second flag means buffer empty in transmit, overflow in receive.
// - processor clock is crystal divided by 16, 32, 64 or 128.
module obt_bit_timer
   import obt_pkg::*;
#(
   parameter int COUNT_W = OBT_COUNT_W
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic edge_sense_pin_i,
   output logic tx_key_o,
   output logic irq_o,
   output logic irq_done_edge_o,
   output logic irq_empty_ovf_o,
   output logic [7:0] irq_vector_o
);
   // the register layout only has room for a ten-bit count
   if (COUNT_W != 10) begin : g_bad_width
      $error("obt_bit_timer: count width must be 10");
   end

   obt_bus_req_t req;
   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // software-visible state
   logic [7:0] count_low;
   logic [1:0] count_high;
   obt_mode_t mode;
   logic irq_en;
   logic data_bit;
   obt_flags_t flags;
   logic [1:0] irq_mask;
   logic [1:0] clk_select;

   // engine state
   obt_state_t state;
   logic buf_full;
   logic cur_bit;
   logic [9:0] down_cnt;
   logic [9:0] rx_cnt;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_a);
      addr_hit = (a == ref_a);
   endfunction

   logic wr_count, wr_ctrl, wr_mask, wr_clk, rd_ctrl, rd_mask, rd_clk, rd_count;
   assign wr_count = req.wr & addr_hit(req.addr, OBT_ADDR_COUNT_LOW);
   assign wr_ctrl = req.wr & addr_hit(req.addr, OBT_ADDR_CTRL_STATUS);
   assign wr_mask = req.wr & addr_hit(req.addr, OBT_ADDR_IRQ_MASK);
   assign wr_clk = req.wr & addr_hit(req.addr, OBT_ADDR_CLK_SELECT);
   assign rd_count = req.rd & addr_hit(req.addr, OBT_ADDR_COUNT_LOW);
   assign rd_ctrl = req.rd & addr_hit(req.addr, OBT_ADDR_CTRL_STATUS);
   assign rd_mask = req.rd & addr_hit(req.addr, OBT_ADDR_IRQ_MASK);
   assign rd_clk = req.rd & addr_hit(req.addr, OBT_ADDR_CLK_SELECT);

   logic tick;
   obt_tick_gen u_tick (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .div_sel_i(clk_select),
      .tick_o(tick)
   );

   logic pin_level, pin_rise, pin_fall;
   obt_edge_sync u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i(edge_sense_pin_i),
      .level_o(pin_level),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   logic [9:0] period_count;
   assign period_count = {count_high, count_low};

   logic tx_mode, rx_mode;
   assign tx_mode = (mode == OBT_MODE_TX_UNKEYED) || (mode == OBT_MODE_TX_KEYED);
   assign rx_mode = (mode == OBT_MODE_RX);

   // transmit engine events
   logic period_end, take_bit, tx_done;
   assign period_end = tx_mode && (state == OBT_ST_TIMING) && tick && (down_cnt == 10'h000);
   // a bit is taken when idle or when the running period ends
   assign take_bit = tx_mode && buf_full && ((state == OBT_ST_IDLE) || period_end);
   assign tx_done = period_end && !buf_full;

   // receive engine events
   logic rx_edge, rx_ovf;
   assign rx_edge = rx_mode && (pin_rise || pin_fall);
   // overflow is kept even when an edge lands on the same tick
   assign rx_ovf = rx_mode && tick && (rx_cnt == OBT_COUNT_MAX);

   logic set_done_edge, set_empty_ovf;
   assign set_done_edge = tx_done || rx_edge;
   assign set_empty_ovf = take_bit || rx_ovf;

   obt_flags_t next_flags;
   // set wins over the read-clear
   assign next_flags.done_edge = set_done_edge | (flags.done_edge & ~rd_ctrl);
   assign next_flags.empty_ovf = set_empty_ovf | (flags.empty_ovf & ~rd_ctrl);

   logic [7:0] ctrl_view;
   assign ctrl_view = {count_high, mode, irq_en, flags.done_edge, data_bit, flags.empty_ovf};

   logic [7:0] next_rdata;
   assign next_rdata = rd_count ? count_low :
                       rd_ctrl ? ctrl_view :
                       rd_mask ? {6'h00, irq_mask} :
                       rd_clk ? {6'h00, clk_select} : 8'h00;

   // registers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         count_low <= OBT_RST_COUNT_LOW;
         count_high <= OBT_RST_CTRL[7:6];
         mode <= OBT_MODE_OFF;
         irq_en <= 1'b0;
         irq_mask <= OBT_RST_IRQ_MASK;
         clk_select <= OBT_RST_CLK_SELECT;
      end else begin
         if (wr_count || (rx_edge && !wr_ctrl)) begin
            // receive capture of elapsed cycles overrides the low byte
            count_low <= rx_edge ? rx_cnt[7:0] : req.wdata;
         end
         if (wr_ctrl) begin
            count_high <= req.wdata[OBT_BIT_C9:OBT_BIT_C8];
            mode <= obt_mode_t'(req.wdata[OBT_BIT_MODE_HI:OBT_BIT_MODE_LO]);
            irq_en <= req.wdata[OBT_BIT_IRQ_EN];
         end else if (rx_edge) begin
            count_high <= rx_cnt[9:8];
         end
         if (wr_mask) begin
            irq_mask <= req.wdata[1:0];
         end
         if (wr_clk) begin
            clk_select <= req.wdata[1:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         flags <= '0;
         rdata_o <= 8'h00;
      end else begin
         flags <= next_flags;
         rdata_o <= next_rdata;
      end
   end

   // data bit: software buffer in transmit, edge polarity in receive
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         data_bit <= 1'b0;
         buf_full <= 1'b0;
      end else begin
         if (rx_edge) begin
            data_bit <= pin_level;
         end else if (wr_ctrl) begin
            data_bit <= req.wdata[OBT_BIT_DATA];
         end
         // the mode may be set by this very write, so look at the written field
         if (wr_ctrl && req.wdata[OBT_BIT_MODE_LO]) begin
            buf_full <= 1'b1;
         end else if (take_bit || !tx_mode) begin
            buf_full <= 1'b0;
         end
      end
   end

   // counting engine
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state <= OBT_ST_IDLE;
         down_cnt <= 10'h000;
         rx_cnt <= 10'h000;
         cur_bit <= 1'b0;
      end else begin
         case (state)
            OBT_ST_IDLE: begin
               if (take_bit) begin
                  state <= OBT_ST_TIMING;
                  down_cnt <= period_count;
                  cur_bit <= data_bit;
               end else if (rx_mode) begin
                  state <= OBT_ST_RX;
                  rx_cnt <= 10'h000;
               end
            end
            OBT_ST_TIMING: begin
               if (!tx_mode) begin
                  state <= OBT_ST_IDLE;
               end else if (take_bit) begin
                  down_cnt <= period_count;
                  cur_bit <= data_bit;
               end else if (period_end) begin
                  state <= OBT_ST_IDLE;
               end else if (tick) begin
                  down_cnt <= down_cnt - 10'h001;
               end
            end
            OBT_ST_RX: begin
               if (!rx_mode) begin
                  state <= OBT_ST_IDLE;
               end else if (rx_edge) begin
                  rx_cnt <= tick ? 10'h001 : 10'h000;
               end else if (tick) begin
                  // wraps after overflow; software counts the overflows
                  rx_cnt <= rx_cnt + 10'h001;
               end
            end
            default: begin
               state <= OBT_ST_IDLE;
            end
         endcase
      end
   end

   // outputs
   logic next_key;
   assign next_key = (mode == OBT_MODE_TX_KEYED) && (state == OBT_ST_TIMING) && cur_bit;

   logic req_done_edge, req_empty_ovf;
   assign req_done_edge = irq_en && irq_mask[1] && flags.done_edge;
   assign req_empty_ovf = irq_en && irq_mask[0] && flags.empty_ovf;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tx_key_o <= 1'b0;
         irq_o <= 1'b0;
         irq_done_edge_o <= 1'b0;
         irq_empty_ovf_o <= 1'b0;
         irq_vector_o <= 8'h00;
      end else begin
         tx_key_o <= next_key;
         irq_done_edge_o <= req_done_edge;
         irq_empty_ovf_o <= req_empty_ovf;
         irq_o <= req_done_edge | req_empty_ovf;
         // the lower vector address has priority
         irq_vector_o <= req_done_edge ? OBT_VEC_DONE_EDGE :
                         req_empty_ovf ? OBT_VEC_EMPTY_OVF : 8'h00;
      end
   end
endmodule // obt_bit_timer

// ===== sim/obt_bit_timer_sva.sv
`timescale 1ns/1ns
module obt_bit_timer_chk (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic irq_done_edge_o,
   input wire logic irq_empty_ovf_o,
   input wire logic [7:0] irq_vector_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // a control read or any write may legally drop the request
   wire touch = wr_i || (rd_i && addr_i == 8'h21);
   sequence s_unmapped_read;
      rd_i && (addr_i < 8'h20 || addr_i > 8'h23);
   endsequence
   property p_vec_done; irq_done_edge_o |-> irq_vector_o == 8'h02; endproperty
   a_vec_done: assert property (p_vec_done) else $error("done vector wrong");
   property p_vec_ovf; irq_empty_ovf_o && !irq_done_edge_o |-> irq_vector_o == 8'h04; endproperty
   a_vec_ovf: assert property (p_vec_ovf) else $error("empty vector wrong");
   property p_vec_none; !irq_o |-> irq_vector_o == 8'h00; endproperty
   a_vec_none: assert property (p_vec_none) else $error("vector without request");
   property p_irq_or; irq_o == (irq_done_edge_o || irq_empty_ovf_o); endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq not or of requests");
   property p_rdata_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   property p_unmapped; s_unmapped_read |=> rdata_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_release; $rose(rst_n_i) |-> !irq_o && rdata_o == 8'h00; endproperty
   a_release: assert property (p_release) else $error("outputs active after reset");
   property p_irq_fall;
      $fell(irq_o) |-> $past(touch, 1) || $past(touch, 2) || $past(touch, 3) || $past(!rst_n_i);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("request dropped uncleared");
endmodule // obt_bit_timer_chk
bind obt_bit_timer obt_bit_timer_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .irq_done_edge_o(irq_done_edge_o),
   .irq_empty_ovf_o(irq_empty_ovf_o), .irq_vector_o(irq_vector_o));

// ===== sim/obt_rf_partner.sv
`timescale 1ns/1ns
module obt_rf_partner (
   input wire logic mclk_i,
   input wire logic tx_key_i,
   output logic pin_o,
   output int mark_len_o,
   output int key_cycles_o
);
   int run = 0;
   initial pin_o = 1'b0;
   initial mark_len_o = 0;
   initial key_cycles_o = 0;
   always @(posedge mclk_i) begin
      if (tx_key_i) begin
         run <= run + 1;
         key_cycles_o <= key_cycles_o + 1;
      end else if (run != 0) begin
         mark_len_o <= run;
         run <= 0;
      end
   end
   // pin holds its level between edges, like a real input line
   task automatic pulse(input int hi);
      @(posedge mclk_i);
      pin_o <= 1'b1;
      repeat (hi) @(posedge mclk_i);
      pin_o <= 1'b0;
   endtask
endmodule // obt_rf_partner

// ===== sim/obt_bit_timer_tb_top.sv
`timescale 1ns/1ns
module obt_bit_timer_tb_top;
   import obt_pkg::*;
   logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
   logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, irq_vector_o, d, v;
   logic tx_key_o, irq_o, irq_done_edge_o, irq_empty_ovf_o, pin;
   int fail_count = 0, samples_checked = 0, mark_len, key_cycles, ovf_sw = 0;
   int seed = 32'hb97fd791;
   int mreg [4] = '{0, 0, 3, 0};
   always #25 mclk_i = ~mclk_i;
   obt_bit_timer dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .edge_sense_pin_i(pin), .tx_key_o(tx_key_o),
      .irq_o(irq_o), .irq_done_edge_o(irq_done_edge_o), .irq_empty_ovf_o(irq_empty_ovf_o),
      .irq_vector_o(irq_vector_o));
   obt_rf_partner p (.mclk_i(mclk_i), .tx_key_i(tx_key_o), .pin_o(pin), .mark_len_o(mark_len),
      .key_cycles_o(key_cycles));
   task print_verdict;
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_n(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("MISMATCH %0t length %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= x;
      wr_i <= 1'b1;
      if (a >= 8'h20 && a <= 8'h23) mreg[a - 8'h20] = x;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // 1: done/edge request, 0: empty/overflow request
   task automatic wait_irq(input bit done, input int bound);
      int n;
      for (n = 0; n < bound; n++) begin
         @(posedge mclk_i);
         #1;
         if ((done ? irq_done_edge_o : irq_empty_ovf_o) === 1'b1) return;
      end
      fail_count++;
      $display("MISMATCH %0t request never came", $time);
      print_verdict();
   endtask
   task service(input bit b);
      wait_irq(0, 400);
      rd(8'h21);
      repeat (3) @(posedge mclk_i);
      wr(8'h21, 8'h38 | {6'h0, b, 1'b0});
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(8'h20 + i[7:0]);
         chk(d, i < 4 ? mreg[i][7:0] : 8'h00);
      end
      v = 8'($random(seed));
      wr(8'h20, v);
      wr(8'h21, v & 8'hca);
      rd(8'h20);
      chk(d, mreg[0][7:0]);
      rd(8'h21);
      chk(d, mreg[1][7:0]);
      wr(8'h23, 8'h03);
      wr(8'h20, 8'h02);
      wr(8'h22, 8'h00);
      wr(8'h21, 8'h1a);
      // masked run: no request expected, so a fixed wait
      repeat (150) @(posedge mclk_i);
      chk({7'h0, irq_o}, 8'h00);
      rd(8'h21);
      chk(d & 8'hfd, 8'h1d);
      rd(8'h21);
      chk(d & 8'hfd, 8'h18);
      chk_n(key_cycles, 0, 0);
      wr(8'h22, 8'h03);
      wr(8'h21, 8'h3a);
      service(1'b0);
      service(1'b1);
      wait_irq(1, 400);
      repeat (2) @(posedge mclk_i);
      chk(irq_vector_o, 8'h02);
      chk_n(mark_len, 48, 48);
      rd(8'h21);
      chk(d & 8'h05, 8'h05);
      wr(8'h21, 8'h28);
      rd(8'h21);
      fork
         p.pulse(160);
         begin
            wait_irq(1, 100);
            rd(8'h21);
            chk(d & 8'h06, 8'h06);
            repeat (3) @(posedge mclk_i);
         end
      join
      wait_irq(1, 100);
      rd(8'h21);
      chk(d & 8'hc6, 8'h04);
      rd(8'h20);
      chk_n(d, 9, 11);
      wait_irq(0, 20000);
      #1 chk(irq_vector_o, 8'h04);
      rd(8'h21);
      chk(d & 8'h05, 8'h01);
      if (d[0] === 1'b1) ovf_sw++;
      chk_n(ovf_sw, 1, 1);
      print_verdict();
   end
endmodule // obt_bit_timer_tb_top
